// ==== hw/lxcd_defs.svh ====
// Purpose: Constants of the line transceiver control block (offsets, bit fields, timing).
// Assumes: Included by bare name from the package and the control module.
// Notes: Times are kept in their own unit; the power-up and pin reset cycle counts derive from the clock period, the others are fixed.
`ifndef LXCD_DEFS_SVH
`define LXCD_DEFS_SVH

// ****************************************************************
// Register map
// ****************************************************************
`define LXCD_ADDR_W 8
`define LXCD_DATA_W 8
`define LXCD_OFS_CTRL 8'h10
`define LXCD_RDATA_UNMAPPED 8'h00
`define LXCD_CTRL_RESET 8'h00

// ****************************************************************
// Bit positions of the input and output data bytes, and the pending-interrupt mode code
// ****************************************************************
`define LXCD_BIT_LOSS 0
`define LXCD_BIT_CODER 2
`define LXCD_BIT_REMOTE 5
`define LXCD_BIT_LOCAL 6
`define LXCD_BIT_ONES 7
`define LXCD_MODE_IRQ 3'b011

// ****************************************************************
// Timing
// ****************************************************************
`define LXCD_CLK_PERIOD_PS 8000
`define LXCD_PWRUP_MS 32
`define LXCD_PIN_RESET_NS 200
`define LXCD_PWRUP_CYC (`LXCD_PWRUP_MS * 1000000 / (`LXCD_CLK_PERIOD_PS / 1000))
`define LXCD_PIN_RESET_CYC ((`LXCD_PIN_RESET_NS * 1000 + `LXCD_CLK_PERIOD_PS - 1) / `LXCD_CLK_PERIOD_PS)
`define LXCD_MODE_TOGGLE_CYC 64
`define LXCD_TXCLK_LOSS_CYC 256
`define LXCD_ATTN_BIT_CYC 16
`define LXCD_ATTN_FRAME_BITS 4

`endif

// ==== hw/lxcd_pkg.sv ====
// Purpose: Types shared by the line transceiver control block.
// Assumes: Constants come from lxcd_defs.svh.
// Notes: Power-up sequencer states are one-hot.
`include "lxcd_defs.svh"

package lxcd_pkg;
    typedef logic [`LXCD_ADDR_W-1:0] lxcd_addr_t;
    typedef logic [`LXCD_DATA_W-1:0] lxcd_data_t;
    typedef enum logic [1:0] {
        LXCD_ST_CALIB = 2'b01,
        LXCD_ST_RUN = 2'b10
    } lxcd_state_t;
endpackage

// ==== hw/lxcd_ctrl.sv ====
// Purpose: Control logic of a single E1 line transceiver: signal-loss interrupt, resets, diagnostic loopbacks.
// Assumes: All inputs are synchronous to i_clock; line clocks are sampled as ordinary inputs.
// Notes: Host path uses a plain register port; pin path uses individual mode pins.
`timescale 1ns/1ps
`include "lxcd_defs.svh"

module lxcd_ctrl #(
    parameter int unsigned PWRUP_CYC = `LXCD_PWRUP_CYC,
    parameter int unsigned PIN_RESET_CYC = `LXCD_PIN_RESET_CYC,
    parameter int unsigned TXCLK_LOSS_CYC = `LXCD_TXCLK_LOSS_CYC,
    parameter int unsigned ATTN_BIT_CYC = `LXCD_ATTN_BIT_CYC
) (
    input wire logic i_clock,
    input wire logic i_arst_n,
    input wire lxcd_pkg::lxcd_addr_t i_addr,
    input wire lxcd_pkg::lxcd_data_t i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output lxcd_pkg::lxcd_data_t o_rdata,
    input wire logic i_mode,
    input wire logic i_sample_edge_sel,
    input wire logic i_pin_all_ones_mode,
    input wire logic i_pin_local_loopback,
    input wire logic i_pin_remote_loopback,
    input wire logic i_jitter_path_sel,
    input wire logic i_xtal_grounded,
    input wire logic i_signal_loss,
    input wire logic [1:0] i_eq_setting,
    input wire logic i_tx_clk_in,
    input wire logic i_mclk_in,
    input wire logic i_tx_pos_in,
    input wire logic i_tx_neg_in,
    input wire logic i_rx_clk_in,
    input wire logic i_line_rx_pos,
    input wire logic i_line_rx_neg,
    output logic o_irq_n_o,
    output logic o_irq_n_oe,
    output logic o_line_tx_pos,
    output logic o_line_tx_neg,
    output logic o_rx_pos_out,
    output logic o_rx_neg_out,
    output logic o_attenuation_code_out,
    output logic o_calib_busy,
    output logic o_rx_ref_mclk,
    output logic o_coder_enable,
    output logic o_pin_mode
);
    import lxcd_pkg::*;

    // ****************************************************************
    // Declarations
    // ****************************************************************
    lxcd_state_t state_q;
    logic [31:0] pwrup_cnt_q;
    lxcd_data_t ctrl_q;
    logic irq_pend_q;
    logic loss_q;
    logic mode_q;
    logic [7:0] mode_quiet_q;
    logic host_mode;
    logic [7:0] pin_rst_cnt_q;
    logic pin_rst_cmd;
    logic host_rst_cmd;
    logic chip_rst;
    logic ctrl_wr;
    logic all_ones_mode;
    logic local_loopback;
    logic remote_loopback;
    logic ones_active;
    logic txclk_q;
    logic mclk_q;
    logic rxclk_q;
    logic txclk_rise;
    logic mclk_rise;
    logic rxclk_rise;
    logic rxclk_fall;
    logic [15:0] txclk_quiet_q;
    logic txclk_missing;
    logic ones_tick;
    logic ones_polarity_q;
    logic [1:0] jitter_stage_q;
    logic rx_update;
    logic [15:0] attn_cnt_q;
    logic [2:0] attn_bit_q;
    logic [3:0] attn_shift_q;
    lxcd_data_t status_byte;

    // ****************************************************************
    // Control path selection and shared mode decode
    // ****************************************************************
    // A mode pin that keeps toggling is driven by the receive clock: pin mode with coders on.
    always_ff @(posedge i_clock or negedge i_arst_n) begin
        if (!i_arst_n) begin
            mode_q <= 1'b0;
            mode_quiet_q <= 8'h00;
        end else begin
            mode_q <= i_mode;
            if (mode_q != i_mode) begin
                mode_quiet_q <= 8'h00;
            end else if (mode_quiet_q != 8'(`LXCD_MODE_TOGGLE_CYC)) begin
                mode_quiet_q <= mode_quiet_q + 8'h01;
            end
        end
    end

    // Host only with a steady high; low or toggling selects pins
    assign host_mode = mode_q && (mode_quiet_q == 8'(`LXCD_MODE_TOGGLE_CYC));

    assign ctrl_wr = i_wr && (i_addr == `LXCD_OFS_CTRL) && host_mode;
    assign host_rst_cmd = ctrl_wr && i_wdata[`LXCD_BIT_REMOTE] && i_wdata[`LXCD_BIT_LOCAL]
                          && !i_wdata[`LXCD_BIT_ONES];

    // Pin reset needs the pattern held the full time, which the controlling logic guarantees
    always_ff @(posedge i_clock or negedge i_arst_n) begin
        if (!i_arst_n) begin
            pin_rst_cnt_q <= 8'h00;
        end else if (!host_mode && i_pin_remote_loopback && i_pin_local_loopback && !i_pin_all_ones_mode) begin
            if (pin_rst_cnt_q != 8'(PIN_RESET_CYC)) begin
                pin_rst_cnt_q <= pin_rst_cnt_q + 8'h01;
            end
        end else begin
            pin_rst_cnt_q <= 8'h00;
        end
    end

    assign pin_rst_cmd = (pin_rst_cnt_q == 8'(PIN_RESET_CYC) - 8'h01);
    assign chip_rst = host_rst_cmd || pin_rst_cmd;

    // Both control paths feed one set of mode controls
    always_comb begin
        if (host_mode) begin
            all_ones_mode = ctrl_q[`LXCD_BIT_ONES];
            local_loopback = ctrl_q[`LXCD_BIT_LOCAL];
            remote_loopback = ctrl_q[`LXCD_BIT_REMOTE];
        end else begin
            all_ones_mode = i_pin_all_ones_mode;
            local_loopback = i_pin_local_loopback && !i_pin_remote_loopback;
            remote_loopback = i_pin_remote_loopback && !i_pin_local_loopback;
        end
    end

    // All ones coexists with local loop but never with remote loop
    assign ones_active = all_ones_mode && !remote_loopback;

    // ****************************************************************
    // Power-up calibration sequence
    // ****************************************************************
    always_ff @(posedge i_clock or negedge i_arst_n) begin
        if (!i_arst_n) begin
            state_q <= LXCD_ST_CALIB;
            pwrup_cnt_q <= 32'h0000_0000;
        end else begin
            unique case (state_q)
                LXCD_ST_CALIB: begin
                    if (pwrup_cnt_q == PWRUP_CYC - 1) begin
                        state_q <= LXCD_ST_RUN;
                    end else begin
                        pwrup_cnt_q <= pwrup_cnt_q + 32'h0000_0001;
                    end
                end
                LXCD_ST_RUN: begin
                    pwrup_cnt_q <= 32'h0000_0000;
                end
                default: begin
                    state_q <= LXCD_ST_CALIB;
                    pwrup_cnt_q <= 32'h0000_0000;
                end
            endcase
        end
    end

    always_ff @(posedge i_clock or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_calib_busy <= 1'b1;
            o_rx_ref_mclk <= 1'b0;
            o_pin_mode <= 1'b1;
            o_coder_enable <= 1'b0;
        end else begin
            o_calib_busy <= (state_q == LXCD_ST_CALIB);
            o_rx_ref_mclk <= i_xtal_grounded;
            o_pin_mode <= !host_mode;
            o_coder_enable <= host_mode ? ctrl_q[`LXCD_BIT_CODER] : (mode_quiet_q != 8'(`LXCD_MODE_TOGGLE_CYC));
        end
    end

    // ****************************************************************
    // Input data byte and signal-loss interrupt
    // ****************************************************************
    always_ff @(posedge i_clock or negedge i_arst_n) begin
        if (!i_arst_n) begin
            ctrl_q <= `LXCD_CTRL_RESET;
        end else if (chip_rst) begin
            ctrl_q <= `LXCD_CTRL_RESET;
        end else if (ctrl_wr) begin
            ctrl_q <= i_wdata;
        end
    end

    always_ff @(posedge i_clock or negedge i_arst_n) begin
        if (!i_arst_n) begin
            loss_q <= 1'b0;
            irq_pend_q <= 1'b0;
        end else begin
            loss_q <= i_signal_loss;
            // A change in the same cycle as a clear still sets the flag
            if (host_mode && (loss_q != i_signal_loss) && !ctrl_q[`LXCD_BIT_LOSS]) begin
                irq_pend_q <= 1'b1;
            end else if (chip_rst) begin
                irq_pend_q <= 1'b0;
            end else if (ctrl_wr && i_wdata[`LXCD_BIT_LOSS] && loss_q) begin
                irq_pend_q <= 1'b0;
            end
        end
    end

    // Open-drain: the data half never drives high
    always_ff @(posedge i_clock or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_irq_n_o <= 1'b0;
            o_irq_n_oe <= 1'b0;
        end else begin
            o_irq_n_o <= 1'b0;
            o_irq_n_oe <= irq_pend_q && host_mode;
        end
    end

    // ****************************************************************
    // Output data byte and read port
    // ****************************************************************
    always_comb begin
        status_byte = 8'h00;
        status_byte[`LXCD_BIT_LOSS] = loss_q;
        status_byte[`LXCD_BIT_CODER] = ctrl_q[`LXCD_BIT_CODER];
        if (irq_pend_q) begin
            {status_byte[`LXCD_BIT_ONES], status_byte[`LXCD_BIT_LOCAL], status_byte[`LXCD_BIT_REMOTE]}
                = `LXCD_MODE_IRQ;
        end else begin
            status_byte[`LXCD_BIT_REMOTE] = remote_loopback;
            status_byte[`LXCD_BIT_LOCAL] = local_loopback;
            status_byte[`LXCD_BIT_ONES] = all_ones_mode;
        end
    end

    always_ff @(posedge i_clock or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_rdata <= `LXCD_RDATA_UNMAPPED;
        end else if (i_rd && (i_addr == `LXCD_OFS_CTRL)) begin
            o_rdata <= status_byte;
        end else begin
            o_rdata <= `LXCD_RDATA_UNMAPPED;
        end
    end

    // ****************************************************************
    // Line clock edges and transmit clock presence
    // ****************************************************************
    always_ff @(posedge i_clock or negedge i_arst_n) begin
        if (!i_arst_n) begin
            txclk_q <= 1'b0;
            mclk_q <= 1'b0;
            rxclk_q <= 1'b0;
        end else begin
            txclk_q <= i_tx_clk_in;
            mclk_q <= i_mclk_in;
            rxclk_q <= i_rx_clk_in;
        end
    end

    assign txclk_rise = i_tx_clk_in && !txclk_q;
    assign mclk_rise = i_mclk_in && !mclk_q;
    assign rxclk_rise = i_rx_clk_in && !rxclk_q;
    assign rxclk_fall = !i_rx_clk_in && rxclk_q;

    always_ff @(posedge i_clock or negedge i_arst_n) begin
        if (!i_arst_n) begin
            txclk_quiet_q <= 16'h0000;
        end else if (txclk_rise) begin
            txclk_quiet_q <= 16'h0000;
        end else if (txclk_quiet_q != 16'(TXCLK_LOSS_CYC)) begin
            txclk_quiet_q <= txclk_quiet_q + 16'h0001;
        end
    end

    assign txclk_missing = (txclk_quiet_q == 16'(TXCLK_LOSS_CYC));
    // Master clock takes over only with jitter attenuation on the transmit side
    assign ones_tick = (txclk_missing && !i_jitter_path_sel) ? mclk_rise : txclk_rise;

    // ****************************************************************
    // Transmit line data
    // ****************************************************************
    always_ff @(posedge i_clock or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_line_tx_pos <= 1'b0;
            o_line_tx_neg <= 1'b0;
            ones_polarity_q <= 1'b0;
            jitter_stage_q <= 2'b00;
        end else begin
            if (txclk_rise) begin
                jitter_stage_q <= {i_tx_pos_in, i_tx_neg_in};
            end
            if (remote_loopback) begin
                if (rxclk_rise) begin
                    o_line_tx_pos <= i_line_rx_pos;
                    o_line_tx_neg <= i_line_rx_neg;
                end
            end else if (ones_active) begin
                if (ones_tick) begin
                    // Marks alternate polarity; transmit data is ignored
                    o_line_tx_pos <= !ones_polarity_q;
                    o_line_tx_neg <= ones_polarity_q;
                    ones_polarity_q <= !ones_polarity_q;
                end
            end else if (txclk_rise) begin
                o_line_tx_pos <= i_tx_pos_in;
                o_line_tx_neg <= i_tx_neg_in;
            end
        end
    end

    // ****************************************************************
    // Receive data outputs
    // ****************************************************************
    // Update on the opposite edge so data are stable at the valid edge
    assign rx_update = (host_mode && i_sample_edge_sel) ? rxclk_rise : rxclk_fall;

    always_ff @(posedge i_clock or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_rx_pos_out <= 1'b0;
            o_rx_neg_out <= 1'b0;
        end else if (local_loopback) begin
            // Line input disconnected; transmit data return via the jitter stage
            if (txclk_rise) begin
                o_rx_pos_out <= jitter_stage_q[1];
                o_rx_neg_out <= jitter_stage_q[0];
            end
        end else if (rx_update) begin
            o_rx_pos_out <= i_line_rx_pos;
            o_rx_neg_out <= i_line_rx_neg;
        end
    end

    // ****************************************************************
    // Attenuation code stream
    // ****************************************************************
    // Frame: start bit 1, code bit L1, code bit L2, stop bit 0
    always_ff @(posedge i_clock or negedge i_arst_n) begin
        if (!i_arst_n) begin
            attn_cnt_q <= 16'h0000;
            attn_bit_q <= 3'h0;
            attn_shift_q <= 4'h0;
            o_attenuation_code_out <= 1'b0;
        end else if (attn_cnt_q == 16'(ATTN_BIT_CYC) - 16'h0001) begin
            attn_cnt_q <= 16'h0000;
            if (attn_bit_q == 3'(`LXCD_ATTN_FRAME_BITS) - 3'h1) begin
                attn_bit_q <= 3'h0;
                attn_shift_q <= {1'b1, i_eq_setting, 1'b0};
                o_attenuation_code_out <= attn_shift_q[0];
            end else begin
                attn_bit_q <= attn_bit_q + 3'h1;
                attn_shift_q <= {attn_shift_q[2:0], 1'b0};
                o_attenuation_code_out <= attn_shift_q[3];
            end
        end else begin
            attn_cnt_q <= attn_cnt_q + 16'h0001;
        end
    end
endmodule

// ==== tb/lxcd_ctrl_checker.sv ====
// Purpose: Concurrent checks on interrupt, register port and reference select of lxcd_ctrl.
// Assumes: One clock domain; writes count only while the block reports host mode.
// Notes: The mask bit is tracked from the write port, since only ports are visible.
`timescale 1ns/1ps
`include "lxcd_defs.svh"
module lxcd_ctrl_checker (
    input wire logic i_clock,
    input wire logic i_arst_n,
    input wire lxcd_pkg::lxcd_addr_t i_addr,
    input wire lxcd_pkg::lxcd_data_t i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    input wire lxcd_pkg::lxcd_data_t o_rdata,
    input wire logic i_signal_loss,
    input wire logic i_xtal_grounded,
    input wire logic o_irq_n_o,
    input wire logic o_irq_n_oe,
    input wire logic o_rx_ref_mclk,
    input wire logic o_pin_mode
);
    import lxcd_pkg::*;
    // ********
    // Mask tracking
    // ********
    logic hwr;
    logic rdc;
    logic mask_q;
    logic unmask_q;
    assign hwr = i_wr && i_addr == `LXCD_OFS_CTRL && !o_pin_mode;
    assign rdc = i_rd && i_addr == `LXCD_OFS_CTRL;
    // A reset command clears the mask even when bit 0 rides along; pin mode may reset unseen
    always_ff @(posedge i_clock or negedge i_arst_n) begin
        if (!i_arst_n) begin
            mask_q <= 1'h0;
            unmask_q <= 1'h1;
        end else if (o_pin_mode) begin
            mask_q <= 1'h0;
            unmask_q <= 1'h0;
        end else if (hwr) begin
            mask_q <= i_wdata[0] && i_wdata[7:5] != 3'h3;
            unmask_q <= !(i_wdata[0] && i_wdata[7:5] != 3'h3);
        end
    end
    default clocking cb @(posedge i_clock); endclocking
    default disable iff (!i_arst_n);
    irq_pull_only_a: assert property (o_irq_n_o == 1'h0)
        else $error("interrupt line driven high");
    irq_raise_a: assert property ($changed(i_signal_loss) && unmask_q && !o_pin_mode |-> ##2 o_irq_n_oe)
        else $error("no interrupt after loss change");
    irq_mask_a: assert property ($rose(o_irq_n_oe) |-> !$past(mask_q))
        else $error("interrupt raised while masked");
    irq_clear_a: assert property (hwr && i_wdata[0] && i_signal_loss && $stable(i_signal_loss)
        ##1 $stable(i_signal_loss) |-> ##1 !o_irq_n_oe) else $error("interrupt not cleared by write");
    reset_cmd_a: assert property (hwr && i_wdata[7:5] == 3'h3 && $stable(i_signal_loss)
        ##1 $stable(i_signal_loss) |-> ##1 !o_irq_n_oe) else $error("interrupt not cleared by reset command");
    rdata_idle_a: assert property (!rdc |=> o_rdata == 8'h00)
        else $error("read data outside a read");
    status_pend_a: assert property (rdc && o_irq_n_oe && $past(o_irq_n_oe) && !$past(i_wr)
        |=> o_rdata[7:5] == 3'h3) else $error("pending status not reported");
    pin_no_irq_a: assert property (o_pin_mode && $past(o_pin_mode) |-> !o_irq_n_oe)
        else $error("interrupt in pin mode");
    ref_sel_a: assert property ($past(i_arst_n, 3) && $stable(i_xtal_grounded) [*3]
        |-> o_rx_ref_mclk == i_xtal_grounded) else $error("receive reference select wrong");
    cover property ($rose(o_irq_n_oe));
    cover property (hwr && i_wdata[0] && o_irq_n_oe);
    cover property (hwr && i_wdata[7:5] == 3'h3 && o_irq_n_oe);
endmodule
bind lxcd_ctrl lxcd_ctrl_checker chk_u (.i_clock(i_clock), .i_arst_n(i_arst_n), .i_addr(i_addr),
    .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_signal_loss(i_signal_loss),
    .i_xtal_grounded(i_xtal_grounded), .o_irq_n_o(o_irq_n_o), .o_irq_n_oe(o_irq_n_oe),
    .o_rx_ref_mclk(o_rx_ref_mclk), .o_pin_mode(o_pin_mode));

// ==== tb/lxcd_framer_model.sv ====
// Purpose: Framer side of the line: one line clock and random bipolar data.
// Assumes: Each clock phase lasts six i_clock cycles.
// Notes: Data moves two cycles after the clock falls, so it is steady around the rise.
`timescale 1ns/1ps
module lxcd_framer_model (
    input wire logic i_clock,
    input wire logic i_arst_n,
    output logic o_line_clk,
    output logic o_tx_pos,
    output logic o_tx_neg,
    output logic o_rx_pos,
    output logic o_rx_neg
);
    int seed = 5;
    int r;
    logic [3:0] cnt_q;
    always @(posedge i_clock or negedge i_arst_n) begin
        if (!i_arst_n) begin
            cnt_q <= 4'h0;
            o_line_clk <= 1'h0;
            {o_tx_pos, o_tx_neg, o_rx_pos, o_rx_neg} <= 4'h0;
        end else begin
            cnt_q <= (cnt_q == 4'hB) ? 4'h0 : cnt_q + 4'h1;
            o_line_clk <= cnt_q < 4'h6;
            if (cnt_q == 4'h8) begin
                r = $random(seed);
                // Never a mark on both rails at once
                {o_tx_pos, o_tx_neg} <= {r[0], r[1] & ~r[0]};
                {o_rx_pos, o_rx_neg} <= {r[2], r[3] & ~r[2]};
            end
        end
    end
endmodule

// ==== tb/tb_lxcd_ctrl.sv ====
// Purpose: Self-checking bench for lxcd_ctrl against a small behavioural model.
// Assumes: Calibration, tx clock loss and attenuation bit period shortened by parameters.
// Notes: Line checks sample at the framer clock's fall, far from any output update.
`timescale 1ns/1ps
module tb_lxcd_ctrl;
    import lxcd_pkg::*;
    logic i_clock = 0, i_arst_n = 0, i_wr = 0, i_rd = 0, i_mode = 1, loss = 0, xtal = 0;
    logic pr = 0, pl = 0, po = 0, last, jsel = 1, txc_on = 1, cod;
    logic [1:0] prev_t;
    logic [1:0] eq = 0;
    lxcd_addr_t i_addr = 0;
    lxcd_data_t i_wdata = 0, rdata, d, ctrl_m = 0;
    lxcd_data_t modes [6] = '{8'h00, 8'h80, 8'h40, 8'hC0, 8'h20, 8'hA0};
    logic clk_l, tp, tn, rp, rn, oe, txp, txn, rxp, rxn, attn, busy, ref_m, pin_m;
    int failures = 0, checks_done = 0, seed = 19, cyc = 0, pend_m = 0, k, n;
    lxcd_framer_model fr_u (.i_clock(i_clock), .i_arst_n(i_arst_n), .o_line_clk(clk_l), .o_tx_pos(tp),
        .o_tx_neg(tn), .o_rx_pos(rp), .o_rx_neg(rn));
    lxcd_ctrl #(.PWRUP_CYC(50), .TXCLK_LOSS_CYC(16), .ATTN_BIT_CYC(4)) dut_u (.i_clock(i_clock),
        .i_arst_n(i_arst_n), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(rdata),
        .i_mode(i_mode), .i_sample_edge_sel(1'h1), .i_pin_all_ones_mode(po), .i_pin_local_loopback(pl),
        .i_pin_remote_loopback(pr), .i_jitter_path_sel(jsel), .i_xtal_grounded(xtal), .i_signal_loss(loss),
        .i_eq_setting(eq), .i_tx_clk_in(clk_l & txc_on), .i_mclk_in(clk_l), .i_tx_pos_in(tp), .i_tx_neg_in(tn),
        .i_rx_clk_in(clk_l), .i_line_rx_pos(rp), .i_line_rx_neg(rn), .o_irq_n_o(), .o_irq_n_oe(oe),
        .o_line_tx_pos(txp), .o_line_tx_neg(txn), .o_rx_pos_out(rxp), .o_rx_neg_out(rxn),
        .o_attenuation_code_out(attn), .o_calib_busy(busy), .o_rx_ref_mclk(ref_m), .o_coder_enable(cod),
        .o_pin_mode(pin_m));
    // ********
    // Checking and bus tasks
    // ********
    task automatic print_verdict();
        $display("checks %0d failures %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
        checks_done++;
        if (got !== exp) begin
            failures++;
            $display("unexpected at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask
    function automatic lxcd_data_t stat();
        return {pend_m[0] ? 3'h3 : ctrl_m[7:5], 2'h0, ctrl_m[2], 1'h0, loss};
    endfunction
    task automatic wr(input lxcd_data_t v);
        @(posedge i_clock);
        i_wr <= 1'h1;
        i_addr <= 8'h10;
        i_wdata <= v;
        @(posedge i_clock);
        i_wr <= 1'h0;
        if (v[7:5] == 3'h3) begin
            ctrl_m = 8'h00;
            pend_m = 0;
        end else begin
            pend_m = (v[0] && loss) ? 0 : pend_m;
            ctrl_m = v;
        end
        @(posedge i_clock);
        @(negedge i_clock);
        chk(oe, pend_m[0], "interrupt after write");
        chk(cod, ctrl_m[2], "coder enable");
    endtask
    task automatic rd(input lxcd_addr_t a, input lxcd_data_t e);
        @(posedge i_clock);
        i_rd <= 1'h1;
        i_addr <= a;
        @(posedge i_clock);
        i_rd <= 1'h0;
        @(negedge i_clock);
        chk(rdata, e, "read");
    endtask
    task automatic set_loss(input logic v);
        @(posedge i_clock);
        loss <= v;
        pend_m = (!ctrl_m[0] && i_mode) ? 1 : pend_m;
        repeat (3) @(posedge i_clock);
        @(negedge i_clock);
        chk(oe, pend_m[0], "interrupt after loss change");
    endtask
    task automatic wait_mode(input logic v);
        for (n = 0; n < 200 && pin_m !== v; n++) @(negedge i_clock);
        chk(pin_m, v, "control mode");
    endtask
    // Mode bits are ones, local, remote from high to low
    task automatic line_chk(input logic [2:0] m);
        repeat (2) @(negedge clk_l);
        last = txp;
        prev_t = {tp, tn};
        repeat (6) begin
            @(negedge clk_l);
            if (m[0]) chk({txp, txn}, {rp, rn}, "remote loop tx");
            else if (m[2]) chk({txp ^ txn, txp}, {1'h1, !last}, "all ones tx");
            else chk({txp, txn}, {tp, tn}, "tx data");
            // Local loop returns transmit data one line clock late through the jitter stage
            chk({rxp, rxn}, m[1] ? prev_t : {rp, rn}, "rx data");
            last = txp;
            prev_t = {tp, tn};
        end
    endtask
    initial begin
        forever #4 i_clock = ~i_clock;
    end
    always @(posedge i_clock) begin
        cyc++;
        if (cyc == 5000) begin
            failures++;
            print_verdict();
        end
    end
    // ********
    // Main sequence
    // ********
    initial begin
        repeat (2) @(posedge i_clock);
        i_arst_n <= 1'h1;
        repeat (40) @(negedge i_clock);
        chk(busy, 8'h01, "calibrating");
        repeat (20) @(negedge i_clock);
        chk(busy, 8'h00, "calibrated");
        for (k = 0; k < 4; k++) begin
            @(posedge i_clock);
            eq <= 2'(k);
            repeat (20) @(posedge i_clock);
            n = 0;
            repeat (64) begin
                @(negedge i_clock);
                n += attn;
            end
            chk(8'(n), 8'(16 * (1 + k[1] + k[0])), "attenuation ones");
        end
        wait_mode(1'h0);
        for (k = 0; k < 6; k++) begin
            wr(modes[k]);
            rd(8'h10, stat());
            line_chk(ctrl_m[7:5]);
        end
        wr(8'h80);
        @(posedge i_clock);
        {jsel, txc_on} <= 2'h0;
        line_chk(3'h4);
        @(posedge i_clock);
        {jsel, txc_on} <= 2'h3;
        for (k = 0; k < 8; k++) begin
            d = 8'($random(seed));
            d[7] = d[7] | (d[6:5] == 2'h3);
            wr(d);
            rd(8'h10, stat());
            d = 8'($random(seed));
            rd(d == 8'h10 ? 8'h00 : d, 8'h00);
        end
        wr(8'h00);
        set_loss(1'h1);
        rd(8'h10, stat());
        wr(8'h01);
        set_loss(1'h0);
        wr(8'h00);
        set_loss(1'h1);
        set_loss(1'h0);
        wr(8'h01);
        wr(8'h60);
        wait_mode(1'h0);
        rd(8'h10, stat());
        for (k = 0; k < 2; k++) begin
            @(posedge i_clock);
            xtal <= !xtal;
            repeat (4) @(negedge i_clock);
            chk(ref_m, xtal, "receive reference");
        end
        wr(8'hC0);
        @(posedge i_clock);
        i_mode <= 1'h0;
        pl <= 1'h1;
        wait_mode(1'h1);
        line_chk(3'h2);
        set_loss(1'h1);
        @(posedge i_clock);
        pr <= 1'h1;
        repeat (30) @(posedge i_clock);
        {pr, pl} <= 2'h0;
        i_mode <= 1'h1;
        ctrl_m = 8'h00;
        wait_mode(1'h0);
        rd(8'h10, stat());
        print_verdict();
    end
endmodule
